/* File: qpil_cfg.svh */
`ifndef QPIL_CFG_SVH
`define QPIL_CFG_SVH
// Byte offsets on the register bus
`define QPIL_OFS_CTRL 12'h000
`define QPIL_OFS_STAT 12'h004
`define QPIL_OFS_TMRH 12'h008
`define QPIL_OFS_TMRL 12'h00C
`define QPIL_OFS_POSH 12'h010
`define QPIL_OFS_POSL 12'h014
`define QPIL_OFS_INIT 12'h018
`define QPIL_OFS_GEC 12'h01C
// Control word field positions
`define QPIL_CTL_ENABLE 15
`define QPIL_CTL_SIDL 13
`define QPIL_CTL_MODE_LO 10
`define QPIL_CTL_MATCHB 9
`define QPIL_CTL_MATCHA 8
`define QPIL_CTL_CCM_LO 0
`define QPIL_CTL_SWAP 2
`define QPIL_CTL_POLA 3
`define QPIL_CTL_POLB 4
`define QPIL_CTL_WMASK 16'hBF1F
`define QPIL_CTL_RESET 16'h0000
// Status word field positions
`define QPIL_ST_HOMEIE 2
`define QPIL_ST_IDXFLAG 1
`define QPIL_ST_IDXIE 0
`define QPIL_ST_HOMEFLAG 3
`define QPIL_TMR_RESET 16'h0000
`endif

/* File: qpil_checker.sv */
`include "qpil_cfg.svh"

module qpil_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Encoder and position
    input wire qpil_pkg::qpil_enc_t encIn,
    input wire logic deviceIdle,
    input wire logic [31:0] positionCount
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [15:0] ctrl;
    logic [11:0] wAddr;
    logic wrPend;
    wire rdReq = hsel && hready && htrans[1] && !hwrite;
    wire cA = (ctrl[2] ? encIn.phaseB : encIn.phaseA) ^ ctrl[3];
    wire cB = (ctrl[2] ? encIn.phaseA : encIn.phaseB) ^ ctrl[4];
    wire hit = cA == ctrl[8] && cB == ctrl[9];
    // Shadow control word, since the register itself is out of sight
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            wAddr <= 12'h000;
            ctrl <= 16'h0000;
        end else begin
            wrPend <= hsel && hready && htrans[1] && hwrite;
            wAddr <= haddr;
            if (wrPend && wAddr == `QPIL_OFS_CTRL) begin
                ctrl <= hwdata[15:0] & `QPIL_CTL_WMASK;
            end
        end
    end
    a_ready_high: assert property (hreadyout)
        else $error("bus wait state seen");
    a_resp_okay: assert property (!hresp)
        else $error("bus error response seen");
    a_ctrl_bit7: assert property (rdReq && haddr == `QPIL_OFS_CTRL |=>
        hrdata[7] == 1'b0 && hrdata[31:16] == 16'h0000) else $error("control bit 7 set");
    a_ctrl_readback: assert property (rdReq && haddr == `QPIL_OFS_CTRL && !wrPend |=>
        hrdata[15:0] == ctrl) else $error("control readback wrong");
    a_stat_upper: assert property (rdReq && haddr == `QPIL_OFS_STAT |=>
        hrdata[31:4] == 28'h000_0000) else $error("status upper bits set");
    a_tmr_word: assert property (rdReq && haddr[11:3] == 9'h001 |=>
        hrdata[31:16] == 16'h0000) else $error("timer word too wide");
    a_halt_off: assert property (!ctrl[15] && !wrPend |=> $stable(positionCount))
        else $error("count moved while disabled");
    a_halt_idle: assert property (ctrl[13] && deviceIdle && !wrPend |=>
        $stable(positionCount)) else $error("count moved in idle");
    a_index_clear: assert property (ctrl[15] && ctrl[1:0] == 2'b00 && !ctrl[13] && !wrPend
        && $rose(encIn.index) && hit |-> ##[1:3] positionCount == 32'h0000_0000)
        else $error("matched index did not clear");
endmodule

bind qpil_top qpil_checker qpil_checker_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .encIn(encIn), .deviceIdle(deviceIdle),
    .positionCount(positionCount)
);

/* File: qpil_enc_model.sv */
module qpil_enc_model (
    // Clock
    input wire logic clk_sys,
    // Encoder lines
    output qpil_pkg::qpil_enc_t encOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial encOut = 4'h0;
    task automatic set_phase(input logic a, input logic b);
        @(posedge clk_sys);
        encOut.phaseA <= a;
        encOut.phaseB <= b;
    endtask
    // Edges five clocks apart keep the count rate well below half the clock
    task automatic step();
        @(posedge clk_sys);
        encOut.phaseA <= ~encOut.phaseB;
        encOut.phaseB <= encOut.phaseA;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic pulse(input logic idx);
        @(posedge clk_sys);
        encOut.index <= idx;
        encOut.home <= ~idx;
        repeat (2) @(posedge clk_sys);
        encOut.index <= 1'b0;
        encOut.home <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

/* File: qpil_pkg.sv */
package qpil_pkg;
    typedef enum logic [2:0] {
        QPIL_INIT_NONE,
        QPIL_INIT_CLR_EVERY,
        QPIL_INIT_LOAD_NEXT,
        QPIL_INIT_LOAD_HOME1,
        QPIL_INIT_LOAD_HOME2,
        QPIL_INIT_CLR_GEC,
        QPIL_INIT_MODULO,
        QPIL_INIT_RSVD
    } qpil_init_mode_t;

    typedef struct packed {
        logic phaseA;
        logic phaseB;
        logic index;
        logic home;
    } qpil_enc_t;

    typedef enum logic [1:0] {
        QPIL_SEQ_WAIT_HOME,
        QPIL_SEQ_WAIT_FIRST,
        QPIL_SEQ_WAIT_SECOND
    } qpil_seq_t;
endpackage

/* File: qpil_top.sv */
// Register access over AHB-Lite and the address map were left to the implementer.
`include "qpil_cfg.svh"

// Notes on behaviour
// - Mode 110 gives modulo counting
// - Mode 101 clears count at compare
// - Mode 100 loads on second post-home index
// - Mode 011 loads on first post-home index
// - Mode 010 loads on next index only
// - Mode 001 clears on every index
// - Mode 000 index leaves count alone outside quadrature mode
// - Bit 9 sets phase B match level
// - Bit 8 sets phase A match level
// - Control bit 7 reads zero
// - Timer counter modes ignore init mode, except for the home flag of modes 011/100
// - Quadrature mode index match clears count, unless a load in mode 010/011/100 fires
// - Swap and polarity before match
// - Status bit 2 home interrupt enable
// - Status bit 1 index event flag
// - Status bit 0 index interrupt enable
// - Home flag only in modes 011/100
// - Timer high word via high register
// - Timer low word, both reset zero
// - Disabled counters stop, registers stay accessible
// - Stop-in-idle halts module in idle
module qpil_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Encoder and system
    input wire qpil_pkg::qpil_enc_t encIn,
    input wire logic deviceIdle,
    // Position out
    output logic [31:0] positionCount
);
    // Bus address phase capture
    logic wrPend;
    logic [11:0] wrAddr;
    wire logic addrPhase = hsel && hready && htrans[1];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            wrAddr <= 12'h000;
        end else begin
            wrPend <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr <= haddr;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire logic wrCtrl = wrPend && (wrAddr == `QPIL_OFS_CTRL);
    wire logic wrStat = wrPend && (wrAddr == `QPIL_OFS_STAT);
    wire logic wrTmrH = wrPend && (wrAddr == `QPIL_OFS_TMRH);
    wire logic wrTmrL = wrPend && (wrAddr == `QPIL_OFS_TMRL);
    wire logic wrPosH = wrPend && (wrAddr == `QPIL_OFS_POSH);
    wire logic wrPosL = wrPend && (wrAddr == `QPIL_OFS_POSL);
    wire logic wrInit = wrPend && (wrAddr == `QPIL_OFS_INIT);
    wire logic wrGec = wrPend && (wrAddr == `QPIL_OFS_GEC);

    // Registers
    logic [15:0] ctrl;
    logic homeIe;
    logic idxIe;
    logic idxFlag;
    logic homeFlag;
    logic [31:0] intervalTimer;
    logic [31:0] initValue;
    logic [31:0] gecValue;

    wire logic [2:0] modeBits = ctrl[`QPIL_CTL_MODE_LO +: 3];
    wire qpil_pkg::qpil_init_mode_t initMode = qpil_pkg::qpil_init_mode_t'(modeBits);
    wire logic [1:0] counterMode = ctrl[`QPIL_CTL_CCM_LO +: 2];
    wire logic matchB = ctrl[`QPIL_CTL_MATCHB];
    wire logic matchA = ctrl[`QPIL_CTL_MATCHA];
    wire logic swapAB = ctrl[`QPIL_CTL_SWAP];
    wire logic polA = ctrl[`QPIL_CTL_POLA];
    wire logic polB = ctrl[`QPIL_CTL_POLB];

    // Module runs only when enabled and not held off in idle
    wire logic running = ctrl[`QPIL_CTL_ENABLE]
        && !(ctrl[`QPIL_CTL_SIDL] && deviceIdle);
    wire logic timerMode = counterMode[1];
    wire logic quadMode = (counterMode == 2'b00);

    // Phase conditioning ahead of the match
    wire logic swA = swapAB ? encIn.phaseB : encIn.phaseA;
    wire logic swB = swapAB ? encIn.phaseA : encIn.phaseB;
    wire logic phA = swA ^ polA;
    wire logic phB = swB ^ polB;

    // Index taken on its rising edge, qualified by phase match
    logic [3:0] histPrev;
    wire logic idxPrev = histPrev[3];
    wire logic homePrev = histPrev[2];
    wire logic phAPrev = histPrev[1];
    wire logic phBPrev = histPrev[0];
    wire logic phaseMatch = (phA == matchA) && (phB == matchB);
    wire logic idxEvent = running && encIn.index && !idxPrev && phaseMatch;
    wire logic homeEvent = running && encIn.home && !homePrev;

    // Quadrature decode: x4 counting
    wire logic stepA = phA ^ phAPrev;
    wire logic stepB = phB ^ phBPrev;
    wire logic countUp = (stepA && (phA != phB)) || (stepB && (phA == phB));
    wire logic countDn = (stepA && (phA == phB)) || (stepB && (phA != phB));
    wire logic quadStep = running && quadMode && (stepA ^ stepB);

    // Home then index sequencing
    qpil_pkg::qpil_seq_t seqState;
    qpil_pkg::qpil_seq_t next_seqState;
    logic loadNextDone;
    wire logic firstSeen = (seqState == qpil_pkg::QPIL_SEQ_WAIT_SECOND);
    wire logic armed = (seqState == qpil_pkg::QPIL_SEQ_WAIT_FIRST) || firstSeen;
    wire logic homeMode = (initMode == qpil_pkg::QPIL_INIT_LOAD_HOME1)
        || (initMode == qpil_pkg::QPIL_INIT_LOAD_HOME2);
    wire logic idxInit = idxEvent && !timerMode;

    wire logic doClrIdx = idxInit && (quadMode
        || (initMode == qpil_pkg::QPIL_INIT_CLR_EVERY));
    wire logic doLoadNext = idxInit && !loadNextDone
        && (initMode == qpil_pkg::QPIL_INIT_LOAD_NEXT);
    wire logic doLoadH1 = idxInit && armed
        && (initMode == qpil_pkg::QPIL_INIT_LOAD_HOME1);
    wire logic doLoadH2 = idxInit && armed && firstSeen
        && (initMode == qpil_pkg::QPIL_INIT_LOAD_HOME2);
    wire logic doLoad = doLoadNext || doLoadH1 || doLoadH2;
    wire logic atGec = !timerMode && (positionCount == gecValue)
        && (initMode == qpil_pkg::QPIL_INIT_CLR_GEC);
    wire logic modulo = !timerMode
        && (initMode == qpil_pkg::QPIL_INIT_MODULO);
    // Modes 000 and 111 produce no index action above outside quadrature mode

    logic [31:0] next_position;
    always_comb begin
        next_position = positionCount;
        if (quadStep && countUp) begin
            if (modulo && positionCount == gecValue) begin
                next_position = initValue;
            end else begin
                next_position = positionCount + 32'h0000_0001;
            end
        end else if (quadStep && countDn) begin
            if (modulo && positionCount == initValue) begin
                next_position = gecValue;
            end else begin
                next_position = positionCount - 32'h0000_0001;
            end
        end
        if (running && atGec) begin
            next_position = 32'h0000_0000;
        end
        if (doLoad) begin
            next_position = initValue;
        end else if (doClrIdx) begin
            next_position = 32'h0000_0000;
        end
        if (wrPosH) begin
            next_position = {hwdata[15:0], positionCount[15:0]};
        end
        if (wrPosL) begin
            next_position = {positionCount[31:16], hwdata[15:0]};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            positionCount <= 32'h0000_0000;
        end else begin
            positionCount <= next_position;
        end
    end

    // Last cycle's inputs, for edge and step detection
    qpil_delay #(
        .WIDTH(4)
    ) qpil_delay_i (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din({encIn.index, encIn.home, phA, phB}),
        .dout(histPrev)
    );

    // Sequencer: home arms, index loads; any control word write restarts it
    always_comb begin
        next_seqState = seqState;
        case (seqState)
            qpil_pkg::QPIL_SEQ_WAIT_HOME: begin
                if (homeEvent && homeMode) begin
                    next_seqState = qpil_pkg::QPIL_SEQ_WAIT_FIRST;
                end
            end
            qpil_pkg::QPIL_SEQ_WAIT_FIRST: begin
                if (homeEvent && homeMode) begin
                    next_seqState = qpil_pkg::QPIL_SEQ_WAIT_FIRST;
                end else if (doLoadH1) begin
                    next_seqState = qpil_pkg::QPIL_SEQ_WAIT_HOME;
                end else if (idxInit) begin
                    next_seqState = qpil_pkg::QPIL_SEQ_WAIT_SECOND;
                end
            end
            qpil_pkg::QPIL_SEQ_WAIT_SECOND: begin
                if (homeEvent && homeMode) begin
                    next_seqState = qpil_pkg::QPIL_SEQ_WAIT_FIRST;
                end else if (doLoadH1 || doLoadH2) begin
                    next_seqState = qpil_pkg::QPIL_SEQ_WAIT_HOME;
                end
            end
            default: begin
                next_seqState = qpil_pkg::QPIL_SEQ_WAIT_HOME;
            end
        endcase
        if (wrCtrl) begin
            next_seqState = qpil_pkg::QPIL_SEQ_WAIT_HOME;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seqState <= qpil_pkg::QPIL_SEQ_WAIT_HOME;
        end else begin
            seqState <= next_seqState;
        end
    end

    // One-shot of the next-index load; any control word write rearms it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            loadNextDone <= 1'b0;
        end else if (wrCtrl) begin
            loadNextDone <= 1'b0;
        end else if (doLoadNext) begin
            loadNextDone <= 1'b1;
        end
    end

    // Control word; unimplemented bits, bit 7 among them, hold zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `QPIL_CTL_RESET;
        end else if (wrCtrl) begin
            ctrl <= hwdata[15:0] & `QPIL_CTL_WMASK;
        end
    end

    // Status: flags cleared by writing zero; an event in the same cycle wins
    wire logic idxClr = wrStat && !hwdata[`QPIL_ST_IDXFLAG];
    wire logic homeClr = wrStat && !hwdata[`QPIL_ST_HOMEFLAG];
    wire logic homeSet = homeEvent && homeMode;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            homeIe <= 1'b0;
            idxIe <= 1'b0;
        end else if (wrStat) begin
            homeIe <= hwdata[`QPIL_ST_HOMEIE];
            idxIe <= hwdata[`QPIL_ST_IDXIE];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idxFlag <= 1'b0;
        end else if (idxEvent) begin
            idxFlag <= 1'b1;
        end else if (idxClr) begin
            idxFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            homeFlag <= 1'b0;
        end else if (homeSet) begin
            homeFlag <= 1'b1;
        end else if (homeClr) begin
            homeFlag <= 1'b0;
        end
    end

    // Interval timer counts clocks while running
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intervalTimer <= {`QPIL_TMR_RESET, `QPIL_TMR_RESET};
        end else if (wrTmrH) begin
            intervalTimer <= {hwdata[15:0], intervalTimer[15:0]};
        end else if (wrTmrL) begin
            intervalTimer <= {intervalTimer[31:16], hwdata[15:0]};
        end else if (running) begin
            intervalTimer <= intervalTimer + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            initValue <= 32'h0000_0000;
        end else if (wrInit) begin
            initValue <= hwdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gecValue <= 32'h0000_0000;
        end else if (wrGec) begin
            gecValue <= hwdata;
        end
    end

    // Read data: registered in the data phase
    wire logic homeShown = homeFlag && homeMode;
    wire logic [15:0] statWord = {12'h000, homeShown, homeIe, idxFlag, idxIe};
    wire logic [31:0] ctrlWord = {16'h0000, ctrl};
    wire logic [31:0] statRead = {16'h0000, statWord};
    wire logic [31:0] tmrHWord = {16'h0000, intervalTimer[31:16]};
    wire logic [31:0] tmrLWord = {16'h0000, intervalTimer[15:0]};
    wire logic [31:0] posHWord = {16'h0000, positionCount[31:16]};
    wire logic [31:0] posLWord = {16'h0000, positionCount[15:0]};
    logic [31:0] rdMux;
    always_comb begin
        case (haddr)
            `QPIL_OFS_CTRL: rdMux = ctrlWord;
            `QPIL_OFS_STAT: rdMux = statRead;
            `QPIL_OFS_TMRH: rdMux = tmrHWord;
            `QPIL_OFS_TMRL: rdMux = tmrLWord;
            `QPIL_OFS_POSH: rdMux = posHWord;
            `QPIL_OFS_POSL: rdMux = posLWord;
            `QPIL_OFS_INIT: rdMux = initValue;
            `QPIL_OFS_GEC: rdMux = gecValue;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
        end
    end
endmodule

// One-cycle delay line behind the edge and step detectors
module qpil_delay #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else begin
            dout <= din;
        end
    end
endmodule

/* File: tb_top.sv */
`include "qpil_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic deviceIdle = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire [31:0] positionCount;
    qpil_pkg::qpil_enc_t encIn;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 47;
    logic [31:0] rv, pre, init, r1, r2;
    qpil_top qpil_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .encIn(encIn),
        .deviceIdle(deviceIdle), .positionCount(positionCount));
    qpil_enc_model qpil_enc_model_i (.clk_sys(clk_sys), .encOut(encIn));
    initial forever #4 clk_sys = ~clk_sys;

    task automatic close_out();
        $display("mismatches %0d of %0d comparisons", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        if (w) hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask
    task automatic setpos(input logic [31:0] v);
        wr(`QPIL_OFS_POSH, {16'h0000, v[31:16]});
        wr(`QPIL_OFS_POSL, {16'h0000, v[15:0]});
    endtask
    // Phases are set while disabled so that no count slips in
    task automatic trial(input logic [31:0] c, input logic a, input logic b);
        wr(`QPIL_OFS_CTRL, 32'h0000_0000);
        setpos(pre);
        qpil_enc_model_i.set_phase(a, b);
        wr(`QPIL_OFS_CTRL, c);
        qpil_enc_model_i.pulse(1'b1);
    endtask
    function automatic logic [31:0] exp_pos(int m, int k, logic [31:0] p, logic [31:0] i);
        case (m)
            1, 5: return 32'h0000_0000;
            2, 3: return i;
            4: return (k == 2) ? i : p;
            default: return p;
        endcase
    endfunction

    initial begin
        #200000;
        error_cnt++;
        $display("unexpected at %0t: run timed out", $time);
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdc(`QPIL_OFS_CTRL, 32'h0000_0000);
        rdc(`QPIL_OFS_TMRH, 32'h0000_0000);
        rdc(`QPIL_OFS_TMRL, 32'h0000_0000);
        rdc(`QPIL_OFS_STAT, 32'h0000_0000);
        wr(`QPIL_OFS_CTRL, 32'h0000_FFFF);
        rdc(`QPIL_OFS_CTRL, 32'h0000_BF1F);
        wr(`QPIL_OFS_CTRL, 32'h0000_0000);
        rv = $random(seed);
        wr(`QPIL_OFS_TMRH, {16'h0000, rv[31:16]});
        wr(`QPIL_OFS_TMRL, {16'h0000, rv[15:0]});
        rdc(`QPIL_OFS_TMRH, {16'h0000, rv[31:16]});
        rdc(`QPIL_OFS_TMRL, {16'h0000, rv[15:0]});
        wr(12'h020, rv);
        rdc(12'h020, 32'h0000_0000);
        for (int m = 0; m < 8; m++) begin
            init = $random(seed);
            pre = $random(seed);
            rv = $random(seed);
            wr(`QPIL_OFS_CTRL, 32'h0000_0000);
            wr(`QPIL_OFS_INIT, init);
            wr(`QPIL_OFS_GEC, (m == 5) ? pre : ~pre);
            setpos(pre);
            qpil_enc_model_i.set_phase(rv[0], rv[1]);
            wr(`QPIL_OFS_CTRL, {16'h0000, 3'b100, m[2:0], rv[1], rv[0], 8'h01});
            wr(`QPIL_OFS_STAT, 32'h0000_0005);
            qpil_enc_model_i.pulse(1'b0);
            qpil_enc_model_i.pulse(1'b1);
            chk(positionCount, exp_pos(m, 1, pre, init));
            qpil_enc_model_i.pulse(1'b1);
            chk(positionCount, exp_pos(m, 2, pre, init));
            rdc(`QPIL_OFS_STAT, {28'h000_0000, m == 3 || m == 4, 3'b111});
        end
        pre = $random(seed) | 32'h0000_0001;
        trial(32'h0000_8300, 1'b1, 1'b1);
        chk(positionCount, 32'h0000_0000);
        trial(32'h0000_8300, 1'b0, 1'b1);
        chk(positionCount, pre);
        trial(32'h0000_8300, 1'b1, 1'b0);
        chk(positionCount, pre);
        trial(32'h0000_8008, 1'b1, 1'b0);
        chk(positionCount, 32'h0000_0000);
        trial(32'h0000_8204, 1'b1, 1'b0);
        chk(positionCount, 32'h0000_0000);
        trial(32'h0000_8402, 1'b0, 1'b0);
        chk(positionCount, pre);
        wr(`QPIL_OFS_CTRL, 32'h0000_0000);
        wr(`QPIL_OFS_INIT, 32'h0000_0010);
        wr(`QPIL_OFS_GEC, 32'h0000_0020);
        qpil_enc_model_i.set_phase(1'b0, 1'b0);
        setpos(32'h0000_0020);
        wr(`QPIL_OFS_CTRL, 32'h0000_9800);
        qpil_enc_model_i.step();
        r1 = positionCount;
        setpos(32'h0000_0010);
        qpil_enc_model_i.step();
        r2 = positionCount;
        chk({31'h0000_0000, (r1 == 32'h0000_0010 && r2 == 32'h0000_0011)
            || (r1 == 32'h0000_001F && r2 == 32'h0000_0020)}, 32'h0000_0001);
        wr(`QPIL_OFS_CTRL, 32'h0000_0000);
        setpos(pre);
        wr(`QPIL_OFS_CTRL, 32'h0000_A000);
        deviceIdle <= 1'b1;
        qpil_enc_model_i.step();
        chk(positionCount, pre);
        deviceIdle <= 1'b0;
        qpil_enc_model_i.step();
        chk({31'h0000_0000, positionCount !== pre}, 32'h0000_0001);
        wr(`QPIL_OFS_CTRL, 32'h0000_0000);
        rv = positionCount;
        qpil_enc_model_i.step();
        chk(positionCount, rv);
        close_out();
    end
endmodule
